// [rtl/dram_if_pkg.sv]
package dram_if_pkg;
   // Bus widths.
   localparam int ADDR_W    = 16;
   localparam int MA_W      = 7;
   localparam int BANK_W    = 4;
   localparam int NBANK     = 16;
   // Address field positions.
   localparam int BANK_LO   = 12;
   localparam int ROW4_LO   = 0;
   localparam int COL4_LO   = 6;
   localparam int ROW16_LO  = 0;
   localparam int COL16_LO  = 7;
   localparam int QUAD_LO   = 14;
   localparam int ROW4_W    = 6;
   localparam int ROW16_W   = 7;
   // Clock period and timing figures in ns.
   localparam int CLK_NS       = 20;
   localparam int ROW_HOLD_NS  = 30;
   localparam int PRECHARGE_NS = 150;
   // Least times round up to whole cycles.
   localparam int HOLD_CYC = (ROW_HOLD_NS + CLK_NS - 1) / CLK_NS;
   localparam int PRE_CYC  = (PRECHARGE_NS + CLK_NS - 1) / CLK_NS;
   localparam int CNT_W    = 4;
   localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
   localparam logic [CNT_W-1:0] CNT_ONE  = 4'h1;
   localparam logic [CNT_W-1:0] HOLD_CNT = CNT_W'(HOLD_CYC);
   localparam logic [CNT_W-1:0] PRE_CNT  = CNT_W'(PRECHARGE_NS / CLK_NS + ((PRECHARGE_NS % CLK_NS) != 0));

   typedef enum logic [4:0] {
      ST_IDLE   = 5'b0_0001,
      ST_ROW    = 5'b0_0010,
      ST_COL    = 5'b0_0100,
      ST_WAITHI = 5'b0_1000,
      ST_PRE    = 5'b1_0000
   } cyc_state_t;
endpackage

// [rtl/dram_sync2.sv]
`timescale 1ns/1ps
module dram_sync2
   import dram_if_pkg::*;
#(
   parameter int W = 1
) (
   input  wire logic         ref_clk, // System clock.
   input  wire logic         rst,     // Synchronous reset.
   input  wire logic [W-1:0] d,       // Asynchronous input.
   output logic      [W-1:0] q        // Synchronised output.
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } sync_t;

   sync_t st_r;
   sync_t st_nxt;

   always_comb begin
      st_nxt    = st_r;
      st_nxt.s1 = d;
      st_nxt.s2 = st_r.s1;
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         st_r <= '{default: '1};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign q = st_r.s2;
endmodule

// [rtl/dram_bus_interface.sv]
`timescale 1ns/1ps
module dram_bus_interface
   import dram_if_pkg::*;
(
   input  wire logic              ref_clk,             // System clock, 50 MHz.
   input  wire logic              rst,                 // Synchronous reset, active high.
   input  wire logic              memory_request_n,    // Processor memory request, low active.
   input  wire logic              refresh_indicator_n, // Processor refresh flag, low active.
   input  wire logic              rd_n,                // Processor read strobe, low active.
   input  wire logic              wr_n,                // Processor write strobe, low active.
   input  wire logic [ADDR_W-1:0] addr,                // Processor address bus.
   input  wire logic              big_parts,           // High when 16K devices are fitted.
   input  wire logic              early_write,         // High selects write from inverted read.
   input  wire logic              page_hold,           // High keeps row open for page mode.
   output logic      [MA_W-1:0]   ram_addr,            // Multiplexed RAM address.
   output logic      [NBANK-1:0]  ras_n,               // Per-bank row strobes, low active.
   output logic                   cas_n,               // Column strobe to all banks, low active.
   output logic                   ram_we_n,            // RAM write input, low active.
   output logic                   mux_col              // High while column address is shown.
);
   typedef struct packed {
      cyc_state_t            state;
      logic [CNT_W-1:0]      cnt;
      logic [NBANK-1:0]      ras_n;
      logic                  cas_n;
      logic                  mux_col;
      logic                  we_n;
      logic [MA_W-1:0]       ma;
      logic [ADDR_W-1:0]     row_addr;
      logic                  refresh;
   } ctl_t;

   ctl_t ctl_r;
   ctl_t ctl_nxt;

   logic [3:0] pins_s;
   logic       memory_request_n_s;
   logic       refresh_indicator_n_s;
   logic       rd_s;
   logic       wr_s;
   logic [ADDR_W-1:0] addr_s;

   dram_sync2 #(.W(4)) u_sync_ctl (
      .ref_clk (ref_clk),
      .rst     (rst),
      .d       ({memory_request_n, refresh_indicator_n, rd_n, wr_n}),
      .q       (pins_s)
   );

   // The address is stable well before the request, so two stages cost nothing.
   dram_sync2 #(.W(ADDR_W)) u_sync_addr (
      .ref_clk (ref_clk),
      .rst     (rst),
      .d       (addr),
      .q       (addr_s)
   );

   assign memory_request_n_s = pins_s[3];
   assign refresh_indicator_n_s = pins_s[2];
   assign rd_s   = pins_s[1];
   assign wr_s   = pins_s[0];

   function automatic logic [MA_W-1:0] row_bits(input logic [ADDR_W-1:0] a, input logic big);
      if (big) begin
         row_bits = a[ROW16_LO +: ROW16_W];
      end else begin
         row_bits = {1'b0, a[ROW4_LO +: ROW4_W]};
      end
   endfunction

   function automatic logic [MA_W-1:0] col_bits(input logic [ADDR_W-1:0] a, input logic big);
      if (big) begin
         col_bits = a[COL16_LO +: ROW16_W];
      end else begin
         col_bits = {1'b0, a[COL4_LO +: ROW4_W]};
      end
   endfunction

   function automatic logic [NBANK-1:0] bank_sel(input logic [ADDR_W-1:0] a, input logic big);
      logic [BANK_W-1:0] idx;
      idx = big ? {2'b00, a[QUAD_LO +: 2]} : a[BANK_LO +: BANK_W];
      bank_sel = ~(16'h0001 << idx);
   endfunction

   logic row_match;
   assign row_match = (row_bits(addr_s, big_parts) == row_bits(ctl_r.row_addr, big_parts))
                      && (bank_sel(addr_s, big_parts) == bank_sel(ctl_r.row_addr, big_parts));

   always_comb begin
      ctl_nxt = ctl_r;
      // Write strobe either from the processor or, for early write, the inverted read.
      ctl_nxt.we_n = early_write ? ~rd_s : wr_s;
      case (ctl_r.state)
         ST_IDLE: begin
            if (!memory_request_n_s) begin
               ctl_nxt.state    = ST_ROW;
               ctl_nxt.row_addr = addr_s;
               ctl_nxt.refresh  = !refresh_indicator_n_s;
               ctl_nxt.ma       = row_bits(addr_s, big_parts);
               ctl_nxt.cnt      = HOLD_CNT;
               // Refresh strobes every bank; normal access only the decoded bank.
               ctl_nxt.ras_n    = !refresh_indicator_n_s ? '0 : bank_sel(addr_s, big_parts);
            end
         end
         ST_ROW: begin
            if (ctl_r.cnt > CNT_ONE) begin
               ctl_nxt.cnt = ctl_r.cnt - CNT_ONE;
            end else if (ctl_r.refresh) begin
               ctl_nxt.state = ST_WAITHI;
            end else if (!ctl_r.mux_col) begin
               ctl_nxt.mux_col = 1'b1;
               ctl_nxt.ma      = col_bits(ctl_r.row_addr, big_parts);
            end else begin
               ctl_nxt.cas_n = 1'b0;
               ctl_nxt.state = ST_COL;
            end
            if (memory_request_n_s) begin
               ctl_nxt.state   = ST_PRE;
               ctl_nxt.cnt     = PRE_CNT;
               ctl_nxt.ras_n   = '1;
               ctl_nxt.cas_n   = 1'b1;
               ctl_nxt.mux_col = 1'b0;
            end
         end
         ST_COL: begin
            if (memory_request_n_s) begin
               ctl_nxt.cas_n   = 1'b1;
               ctl_nxt.mux_col = 1'b0;
               ctl_nxt.ma      = row_bits(ctl_r.row_addr, big_parts);
               ctl_nxt.state   = page_hold ? ST_WAITHI : ST_PRE;
               ctl_nxt.cnt     = PRE_CNT;
               if (!page_hold) begin
                  ctl_nxt.ras_n = '1;
               end
            end
         end
         ST_WAITHI: begin
            if (ctl_r.refresh) begin
               if (memory_request_n_s) begin
                  ctl_nxt.ras_n = '1;
                  ctl_nxt.state = ST_PRE;
                  ctl_nxt.cnt   = PRE_CNT;
               end
            end else if (!memory_request_n_s) begin
               // Page mode: same row reuses the open row, otherwise close it.
               if (row_match && refresh_indicator_n_s) begin
                  ctl_nxt.row_addr = addr_s;
                  ctl_nxt.ma       = col_bits(addr_s, big_parts);
                  ctl_nxt.mux_col  = 1'b1;
                  ctl_nxt.state    = ST_ROW;
                  ctl_nxt.cnt      = CNT_ONE;
               end else begin
                  ctl_nxt.ras_n = '1;
                  ctl_nxt.state = ST_PRE;
                  ctl_nxt.cnt   = PRE_CNT;
               end
            end else if (!page_hold) begin
               ctl_nxt.ras_n = '1;
               ctl_nxt.state = ST_PRE;
               ctl_nxt.cnt   = PRE_CNT;
            end
         end
         ST_PRE: begin
            // The row strobe stays high for the full precharge however short the gap.
            if (ctl_r.cnt > CNT_ONE) begin
               ctl_nxt.cnt = ctl_r.cnt - CNT_ONE;
            end else begin
               ctl_nxt.cnt   = CNT_ZERO;
               ctl_nxt.state = ST_IDLE;
               ctl_nxt.refresh = 1'b0;
            end
         end
         default: begin
            ctl_nxt.state   = ST_IDLE;
            ctl_nxt.ras_n   = '1;
            ctl_nxt.cas_n   = 1'b1;
            ctl_nxt.mux_col = 1'b0;
         end
      endcase
      // Small parts keep the seventh line grounded in every state, even after a large-part cycle.
      if (!big_parts) begin
         ctl_nxt.ma[MA_W-1] = 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ctl_r <= '{state: ST_IDLE, cnt: CNT_ZERO, ras_n: '1, cas_n: 1'b1, mux_col: 1'b0,
                    we_n: 1'b1, ma: '0, row_addr: '0, refresh: 1'b0};
      end else begin
         ctl_r <= ctl_nxt;
      end
   end

   assign ram_addr = ctl_r.ma;
   assign ras_n    = ctl_r.ras_n;
   assign cas_n    = ctl_r.cas_n;
   assign ram_we_n = ctl_r.we_n;
   assign mux_col  = ctl_r.mux_col;

   property p_ras_on_req;
      @(posedge ref_clk) disable iff (rst)
      (ctl_r.state == ST_IDLE && !memory_request_n_s) |=> (ras_n != '1);
   endproperty
   a_ras_on_req: assert property (p_ras_on_req) else $error("Row strobe not asserted on request.");

   property p_refresh_no_cas;
      @(posedge ref_clk) disable iff (rst)
      ctl_r.refresh |-> (cas_n && !mux_col);
   endproperty
   a_refresh_no_cas: assert property (p_refresh_no_cas) else $error("Column activity during refresh.");

   property p_cas_after_mux;
      @(posedge ref_clk) disable iff (rst)
      $fell(cas_n) |-> $past(mux_col);
   endproperty
   a_cas_after_mux: assert property (p_cas_after_mux) else $error("Column strobe before mux switch.");

   sequence s_req_start;
      ctl_r.state == ST_IDLE && !memory_request_n_s && refresh_indicator_n_s;
   endsequence
   property p_cas_within_two_states;
      @(posedge ref_clk) disable iff (rst)
      s_req_start ##1 (!memory_request_n_s) [*5] |-> !cas_n;
   endproperty
   a_cas_within_two_states: assert property (p_cas_within_two_states) else $error("Column strobe too late.");

   property p_precharge;
      @(posedge ref_clk) disable iff (rst)
      (ctl_r.state != ST_PRE ##1 ctl_r.state == ST_PRE) |-> (ras_n == '1) [*7];
   endproperty
   a_precharge: assert property (p_precharge) else $error("Row strobe precharge too short.");

   property p_one_bank;
      @(posedge ref_clk) disable iff (rst)
      (!ctl_r.refresh && ras_n != '1) |-> $onehot(~ras_n);
   endproperty
   a_one_bank: assert property (p_one_bank) else $error("More than one bank strobed.");

   property p_req_end_idle;
      @(posedge ref_clk) disable iff (rst)
      (memory_request_n_s && ctl_r.state == ST_COL) |=> (cas_n && !mux_col);
   endproperty
   a_req_end_idle: assert property (p_req_end_idle) else $error("Strobes left active after request.");

   property p_early_we;
      @(posedge ref_clk) disable iff (rst)
      early_write |=> (ram_we_n == ~$past(rd_s));
   endproperty
   a_early_we: assert property (p_early_we) else $error("Write input not from read strobe.");

   property p_cs_low;
      @(posedge ref_clk) disable iff (rst)
      !big_parts |=> (ram_addr[MA_W-1] == 1'b0);
   endproperty
   a_cs_low: assert property (p_cs_low) else $error("Seventh address line not low.");
endmodule

// [sim/dram_array_model.sv]
`timescale 1ns/1ps
module dram_array_model
   import dram_if_pkg::*;
(
   input  wire logic [MA_W-1:0]  ram_addr, // Multiplexed address from the controller.
   input  wire logic [NBANK-1:0] ras_n,    // Per-bank row strobes.
   input  wire logic             cas_n,    // Shared column strobe.
   input  wire logic             ram_we_n  // Write input.
);
   wire logic       any_ras_n;
   logic            dout_en;
   logic [MA_W-1:0] row_q;
   logic [MA_W-1:0] col_q;
   int              read_cnt;
   int              early_cnt;
   int              late_cnt;

   assign any_ras_n = &ras_n;
   // A part without an output latch drives its data pin only under an open column of a read.
   assign dout_en = !cas_n && !any_ras_n && ram_we_n;

   initial begin
      row_q = '0;
      col_q = '0;
      read_cnt = 0;
      early_cnt = 0;
      late_cnt = 0;
   end

   // The row latches 1 ns after the falling row strobe, since the address changes in the same step.
   always @(negedge any_ras_n) begin
      #1 row_q = ram_addr;
   end

   // A column strobe without a row strobe only floats outputs and is not counted.
   always @(negedge cas_n) begin
      if (!any_ras_n) begin
         col_q = ram_addr;
         if (!ram_we_n) begin
            early_cnt++;
         end else begin
            read_cnt++;
         end
      end
   end

   // A write input falling under an open column is a delayed write.
   always @(negedge ram_we_n) begin
      if (!cas_n && !any_ras_n) begin
         late_cnt++;
      end
   end
endmodule

// [sim/dram_bus_interface_tb.sv]
`timescale 1ns/1ps
`define CHK(act, exp) begin checks++; if ((act) !== (exp)) begin fail_count++; \
   $display("wrong value at %0t: got %h expected %h", $time, (act), (exp)); end end
module dram_bus_interface_tb
   import dram_if_pkg::*;
;
   logic              ref_clk;
   logic              rst;
   logic              memory_request_n;
   logic              refresh_indicator_n;
   logic              rd_n;
   logic              wr_n;
   logic [ADDR_W-1:0] addr;
   logic              big_parts;
   logic              early_write;
   logic              page_hold;
   logic [MA_W-1:0]   ram_addr;
   logic [NBANK-1:0]  ras_n;
   logic              cas_n;
   logic              ram_we_n;
   logic              mux_col;
   int                checks;
   int                fail_count;
   int                cyc;
   int                last_rise;

   dram_bus_interface i_dut (.ref_clk(ref_clk), .rst(rst), .memory_request_n(memory_request_n),
      .refresh_indicator_n(refresh_indicator_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr),
      .big_parts(big_parts), .early_write(early_write), .page_hold(page_hold), .ram_addr(ram_addr),
      .ras_n(ras_n), .cas_n(cas_n), .ram_we_n(ram_we_n), .mux_col(mux_col));

   dram_array_model i_ram (.ram_addr(ram_addr), .ras_n(ras_n), .cas_n(cas_n), .ram_we_n(ram_we_n));

   always #10 ref_clk = ~ref_clk;

   task automatic test_done;
      $display("checks=%0d fail_count=%0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         fail_count++;
         test_done();
      end
   end

   task automatic tick;
      @(posedge ref_clk);
      #1;
   endtask

   // One processor memory cycle: request, optional late write, release.
   task automatic run_cycle(input logic [ADDR_W-1:0] a, input logic rf, input logic wr,
                            input logic ew, input logic bp);
      logic [NBANK-1:0] mask;
      logic [MA_W-1:0]  row;
      logic [MA_W-1:0]  col;
      int               n;
      int               start;
      int               take;
      mask = rf ? '0 : ~(16'h0001 << (bp ? a[15:14] : a[15:12]));
      row = bp ? a[6:0] : {1'b0, a[5:0]};
      col = bp ? a[13:7] : {1'b0, a[11:6]};
      @(posedge ref_clk);
      start = cyc;
      addr <= a;
      big_parts <= bp;
      early_write <= ew;
      refresh_indicator_n <= ~rf;
      rd_n <= wr | rf;
      memory_request_n <= 1'b0;
      n = 0;
      while (ras_n === {NBANK{1'b1}} && n < 12) begin
         tick();
         n++;
      end
      // Two synchroniser edges and the taking edge, or one edge after a running precharge ends.
      take = (start + 4 > last_rise + int'(PRE_CNT) + 1) ? start + 4 : last_rise + int'(PRE_CNT) + 1;
      `CHK(cyc, take)
      `CHK(cyc - last_rise >= int'(PRE_CNT), 1'b1)
      `CHK(ras_n, mask)
      `CHK(ram_addr, row)
      if (rf) begin
         repeat (4) begin
            tick();
            `CHK({mux_col, cas_n}, 2'b01)
         end
      end else begin
         tick();
         `CHK({mux_col, cas_n}, 2'b01)
         tick();
         `CHK(mux_col, 1'b1)
         `CHK(ram_addr, col)
         `CHK(ram_we_n, ~(wr & ew))
         tick();
         `CHK(cas_n, 1'b0)
         `CHK(i_ram.dout_en, ~(wr & ew))
         if (wr && !ew) begin
            @(posedge ref_clk);
            wr_n <= 1'b0;
            n = 0;
            while (ram_we_n !== 1'b0 && n < 6) begin
               tick();
               n++;
            end
            `CHK({ram_we_n, cas_n}, 2'b00)
         end
      end
      @(posedge ref_clk);
      memory_request_n <= 1'b1;
      refresh_indicator_n <= 1'b1;
      rd_n <= 1'b1;
      wr_n <= 1'b1;
      early_write <= 1'b0;
      n = 0;
      while (ras_n !== {NBANK{1'b1}} && n < 12) begin
         tick();
         n++;
      end
      `CHK({ras_n, cas_n, mux_col}, {{NBANK{1'b1}}, 2'b10})
      `CHK(i_ram.dout_en, 1'b0)
      last_rise = cyc;
   endtask

   task automatic t_reset;
      `CHK({ras_n, cas_n, mux_col, ram_we_n}, {{NBANK{1'b1}}, 3'b101})
      `CHK(ram_addr, 7'h00)
      $display("test reset done");
   endtask

   task automatic t_reads;
      int r0;
      r0 = i_ram.read_cnt;
      run_cycle(16'h5ABC, 1'b0, 1'b0, 1'b0, 1'b0);
      `CHK(i_ram.col_q, 7'h2A)
      run_cycle(16'hC3A5, 1'b0, 1'b0, 1'b0, 1'b1);
      `CHK({i_ram.row_q, i_ram.col_q}, {7'h25, 7'h07})
      `CHK(i_ram.read_cnt - r0, 2)
      $display("test reads done");
   endtask

   task automatic t_refresh;
      int r0;
      r0 = i_ram.read_cnt;
      run_cycle(16'h007F, 1'b1, 1'b0, 1'b0, 1'b1);
      `CHK(i_ram.read_cnt - r0, 0)
      $display("test refresh done");
   endtask

   task automatic t_writes;
      int e0;
      int l0;
      e0 = i_ram.early_cnt;
      l0 = i_ram.late_cnt;
      run_cycle(16'h2F41, 1'b0, 1'b1, 1'b0, 1'b0);
      `CHK(i_ram.late_cnt - l0, 1)
      run_cycle(16'h9D12, 1'b0, 1'b1, 1'b1, 1'b0);
      `CHK(i_ram.early_cnt - e0, 1)
      $display("test writes done");
   endtask

   task automatic t_back_to_back;
      run_cycle(16'hF000, 1'b0, 1'b0, 1'b0, 1'b0);
      run_cycle(16'h0FFF, 1'b1, 1'b0, 1'b0, 1'b0);
      run_cycle(16'h0FFF, 1'b0, 1'b0, 1'b0, 1'b0);
      $display("test back to back done");
   endtask

   // Page mode: a second request to the open row goes straight to the column.
   task automatic t_page;
      int r0;
      int n;
      r0 = i_ram.read_cnt;
      @(posedge ref_clk);
      page_hold <= 1'b1;
      addr <= 16'h3041;
      big_parts <= 1'b0;
      rd_n <= 1'b0;
      memory_request_n <= 1'b0;
      n = 0;
      while (cas_n !== 1'b0 && n < 20) begin
         tick();
         n++;
      end
      `CHK({ras_n, ram_addr}, {16'hFFF7, 7'h01})
      @(posedge ref_clk);
      memory_request_n <= 1'b1;
      rd_n <= 1'b1;
      repeat (4) tick();
      `CHK({ras_n, cas_n, mux_col, ram_addr}, {16'hFFF7, 2'b10, 7'h01})
      @(posedge ref_clk);
      addr <= 16'h3FC1;
      rd_n <= 1'b0;
      memory_request_n <= 1'b0;
      n = 0;
      while (cas_n !== 1'b0 && n < 20) begin
         tick();
         n++;
      end
      `CHK(n < 6, 1'b1)
      `CHK({ras_n, mux_col, ram_addr}, {16'hFFF7, 1'b1, 7'h3F})
      @(posedge ref_clk);
      memory_request_n <= 1'b1;
      rd_n <= 1'b1;
      page_hold <= 1'b0;
      n = 0;
      while (ras_n !== {NBANK{1'b1}} && n < 12) begin
         tick();
         n++;
      end
      `CHK(ras_n, {NBANK{1'b1}})
      `CHK(i_ram.read_cnt - r0, 2)
      last_rise = cyc;
      $display("test page done");
   endtask

   initial begin
      ref_clk = 1'b0;
      rst = 1'b1;
      memory_request_n = 1'b1;
      refresh_indicator_n = 1'b1;
      rd_n = 1'b1;
      wr_n = 1'b1;
      addr = 16'h0000;
      big_parts = 1'b0;
      early_write = 1'b0;
      page_hold = 1'b0;
      checks = 0;
      fail_count = 0;
      cyc = 0;
      last_rise = -100;
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      repeat (3) @(posedge ref_clk);
      #1;
      t_reset();
      t_reads();
      t_refresh();
      t_writes();
      t_back_to_back();
      t_page();
      test_done();
   end
endmodule
